// File: core/wake_seq_pkg.sv
// Constants, field layout and state encoding for the wake-up power sequencer.
// Assumes a single always-on clock of 250 MHz and a plain register port.
package wake_seq_pkg;

	// ----------------------------------------------------------------
	// Register port geometry and offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_KICK_SEL = 4'h4;
	localparam logic [3:0] OFS_FLAGS = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_WAKE_EN = 0;
	localparam int CTL_KICK_EN = 1;
	localparam int CTL_POWER_OFF = 2;
	localparam int CTL_DIV_LO = 4;
	localparam int CTL_DIV_HI = 6;
	localparam int FLG_WAKE = 0;
	localparam int FLG_KICK = 1;
	localparam int STS_PGOOD = 0;
	localparam int STS_REQ = 1;
	localparam int STS_IRQ = 2;
	localparam int STS_STATE_LO = 3;
	localparam int STS_STATE_HI = 4;
	localparam int STS_REQ_PIN = 5;
	localparam int STS_IRQ_PIN = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic RST_WAKE_EN = 1'b0;
	localparam logic RST_KICK_EN = 1'b0;
	localparam logic RST_POWER_OFF = 1'b1;
	localparam logic [2:0] RST_DIV = 3'h0;
	localparam logic [3:0] RST_KICK_SEL = 4'h0;
	localparam logic [1:0] RST_FLAGS = 2'h0;

	// ----------------------------------------------------------------
	// Divider code that lets the countdown chain run (01x)
	// ----------------------------------------------------------------
	localparam logic [2:0] DIV_RUN_MASK = 3'h6;
	localparam logic [2:0] DIV_RUN_VAL = 3'h2;

	// ----------------------------------------------------------------
	// Pin slots in the synchroniser
	// ----------------------------------------------------------------
	localparam int NUM_KICK = 4;
	localparam int PIN_PGOOD = 4;
	localparam int PIN_REQ = 5;
	localparam int PIN_IRQ = 6;
	localparam int NUM_PINS = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int POWER_ON_TIMEOUT_US = 1000;
	localparam int POTO_CYCLES = POWER_ON_TIMEOUT_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Sequencer states, Gray along down -> wait -> on
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_DOWN = 2'b00,
		ST_WAIT = 2'b01,
		ST_ON = 2'b11
	} seq_state_t;

endpackage

// File: core/pin_sync_if.sv
// Interface carrying filtered pin levels and falling-edge pulses.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pin_sync_if #(parameter int N = 7);
	logic [N-1:0] level;
	logic [N-1:0] fall;
	modport src (output level, output fall);
	modport dst (input level, input fall);
endinterface

// File: core/pin_sync.sv
// Three-stage synchroniser with agreement filter and fall detector per pin.
// Assumes pins are asynchronous to clk and idle high after reset.
`timescale 1ns/100ps
module pin_sync
	import wake_seq_pkg::*;
#(
	parameter int N = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [N-1:0] pins,
	pin_sync_if.src s
);

	logic [N-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, fall_reg;
	logic [N-1:0] s1_next, s2_next, s3_next, lvl_next, fall_next;

	// ----------------------------------------------------------------
	// Per-pin filter: level moves once stages two and three agree
	// ----------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_pin
		always_comb begin
			s1_next[i] = pins[i];
			s2_next[i] = s1_reg[i];
			s3_next[i] = s2_reg[i];
			lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
			fall_next[i] = lvl_reg[i] & ~lvl_next[i];
		end
	end

	// Register stages; pins idle high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			lvl_reg <= '1;
			fall_reg <= '0;
		end else if (ce) begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			lvl_reg <= lvl_next;
			fall_reg <= fall_next;
		end
	end

	assign s.level = lvl_reg;
	assign s.fall = fall_reg;

endmodule

// File: core/wake_seq.sv
// Wake-up and kickstart power sequencer running on the always-on clock.
// Assumes alarm_match, osc_running and other_irq_pending come from logic on
// clk; all pins and power_good are asynchronous.
`timescale 1ns/100ps
module wake_seq
	import wake_seq_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = POTO_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [DATA_W-1:0] rd_data,
	input wire logic power_good,
	input wire logic alarm_match,
	input wire logic osc_running,
	input wire logic other_irq_pending,
	input wire logic keyboard_port_pin_sixteen,
	input wire logic serial_a_ring_indicate_n,
	input wire logic serial_b_ring_indicate_n,
	input wire logic infrared_receive_in,
	input wire logic power_request_n_in,
	output logic power_request_n_out,
	output logic power_request_n_oe,
	input wire logic clock_interrupt_n_in,
	output logic clock_interrupt_n_out,
	output logic clock_interrupt_n_oe
);

	localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	pin_sync_if #(.N(NUM_PINS)) sync_bus ();
	logic [NUM_PINS-1:0] raw_pins;

	logic supply_fail;

	// Kick pins in the low slots, then supply and pin readbacks. The supply
	// slot carries the fail level, so the synchroniser's reset value of one
	// reads as no supply: a reset into an unpowered system must not pass
	// through the powered state while the stages fill.
	assign supply_fail = ~power_good;
	assign raw_pins = {clock_interrupt_n_in, power_request_n_in, supply_fail,
		infrared_receive_in, serial_b_ring_indicate_n,
		serial_a_ring_indicate_n, keyboard_port_pin_sixteen};

	pin_sync #(.N(NUM_PINS)) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pins(raw_pins),
		.s(sync_bus)
	);

	logic pgood;
	logic [NUM_KICK-1:0] kick_fall;
	// Filtered supply level turned back into its power-good sense
	assign pgood = ~sync_bus.level[PIN_PGOOD];
	assign kick_fall = sync_bus.fall[NUM_KICK-1:0];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	seq_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic wake_en_reg, wake_en_next;
	logic kick_en_reg, kick_en_next;
	logic power_off_reg, power_off_next;
	logic [2:0] div_reg, div_next;
	logic [NUM_KICK-1:0] kick_sel_reg, kick_sel_next;
	logic wake_flag_reg, wake_flag_next;
	logic kick_flag_reg, kick_flag_next;
	logic req_oe_reg, req_oe_next;
	logic irq_oe_reg, irq_oe_next;
	logic [DATA_W-1:0] rd_data_reg, rd_data_next;

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	logic wake_evt, kick_evt, trigger, div_ok, wr_ctl, wr_sel, wr_flg;

	// Alarm wake and kickstart are each gated by their own enable
	always_comb begin
		wake_evt = alarm_match & wake_en_reg;
		kick_evt = kick_en_reg & (|(kick_fall & kick_sel_reg));
		trigger = wake_evt | kick_evt;
		div_ok = ((div_reg & DIV_RUN_MASK) == DIV_RUN_VAL) && osc_running;
		wr_ctl = wr_strobe && (addr == OFS_CONTROL);
		wr_sel = wr_strobe && (addr == OFS_KICK_SEL);
		wr_flg = wr_strobe && (addr == OFS_FLAGS);
	end

	// ----------------------------------------------------------------
	// Configuration and flags
	// ----------------------------------------------------------------
	// Software writes, hardware sets win over clears in the same cycle
	always_comb begin
		wake_en_next = wake_en_reg;
		kick_en_next = kick_en_reg;
		div_next = div_reg;
		kick_sel_next = kick_sel_reg;
		wake_flag_next = wake_flag_reg;
		kick_flag_next = kick_flag_reg;
		if (wr_ctl) begin
			wake_en_next = wr_data[CTL_WAKE_EN];
			kick_en_next = wr_data[CTL_KICK_EN];
			div_next = wr_data[CTL_DIV_HI:CTL_DIV_LO];
		end
		if (wr_sel) begin
			kick_sel_next = wr_data[NUM_KICK-1:0];
		end
		if (wr_flg && !wr_data[FLG_WAKE]) begin
			wake_flag_next = 1'b0;
		end
		if (wr_flg && !wr_data[FLG_KICK]) begin
			kick_flag_next = 1'b0;
		end
		if (alarm_match) begin
			wake_flag_next = 1'b1;
		end
		if (kick_evt) begin
			kick_flag_next = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Power sequencing
	// ----------------------------------------------------------------
	// Down, waiting for supply, or powered; power-off bit follows
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		power_off_next = power_off_reg;
		if (wr_ctl) begin
			power_off_next = wr_data[CTL_POWER_OFF];
		end
		unique case (state_reg)
			ST_DOWN: begin
				// Sources keep being watched with outputs released
				// The divider check holds back only this battery-mode request
				if (trigger && div_ok) begin
					state_next = ST_WAIT;
					cnt_next = '0;
				end else if (pgood) begin
					// Power came by other means, power-off bit kept, so request stays off if it is set
					state_next = ST_ON;
				end
			end
			ST_WAIT: begin
				// Count runs 0 to CNT_LAST, so a failed attempt holds the
				// request for exactly TIMEOUT_CYCLES cycles
				if (pgood) begin
					state_next = ST_ON;
					power_off_next = 1'b0;
				end else if (cnt_reg == CNT_LAST) begin
					state_next = ST_DOWN;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_ON: begin
				if (!pgood) begin
					state_next = ST_DOWN;
				end else if (trigger) begin
					power_off_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_DOWN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pin enables
	// ----------------------------------------------------------------
	logic irq_src;

	// Request pulled low while waiting or while powered with bit at zero
	// Next values are used so that the interrupt drops on the very edge
	// that clears a flag, and rises with the edge that powers up
	always_comb begin
		irq_src = (wake_flag_next & wake_en_next) |
			(kick_flag_next & kick_en_next) | other_irq_pending;
		req_oe_next = (state_next == ST_WAIT) ||
			((state_next == ST_ON) && !power_off_next);
		// Interrupt only driven while supply is good
		irq_oe_next = (state_next == ST_ON) && irq_src;
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	// Data stand only in the cycle after the read strobe
	always_comb begin
		rd_data_next = '0;
		if (rd_strobe) begin
			unique case (addr)
				OFS_CONTROL: begin
					rd_data_next[CTL_WAKE_EN] = wake_en_reg;
					rd_data_next[CTL_KICK_EN] = kick_en_reg;
					rd_data_next[CTL_POWER_OFF] = power_off_reg;
					rd_data_next[CTL_DIV_HI:CTL_DIV_LO] = div_reg;
				end
				OFS_KICK_SEL: begin
					rd_data_next[NUM_KICK-1:0] = kick_sel_reg;
				end
				OFS_FLAGS: begin
					rd_data_next[FLG_WAKE] = wake_flag_reg;
					rd_data_next[FLG_KICK] = kick_flag_reg;
				end
				OFS_STATUS: begin
					rd_data_next[STS_PGOOD] = pgood;
					rd_data_next[STS_REQ] = req_oe_reg;
					rd_data_next[STS_IRQ] = irq_oe_reg;
					rd_data_next[STS_STATE_HI:STS_STATE_LO] = state_reg;
					rd_data_next[STS_REQ_PIN] = sync_bus.level[PIN_REQ];
					rd_data_next[STS_IRQ_PIN] = sync_bus.level[PIN_IRQ];
				end
				default: begin
					rd_data_next = '0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// All state frozen while ce is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_DOWN;
			cnt_reg <= '0;
			wake_en_reg <= RST_WAKE_EN;
			kick_en_reg <= RST_KICK_EN;
			power_off_reg <= RST_POWER_OFF;
			div_reg <= RST_DIV;
			kick_sel_reg <= RST_KICK_SEL;
			wake_flag_reg <= RST_FLAGS[FLG_WAKE];
			kick_flag_reg <= RST_FLAGS[FLG_KICK];
			req_oe_reg <= 1'b0;
			irq_oe_reg <= 1'b0;
			rd_data_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			wake_en_reg <= wake_en_next;
			kick_en_reg <= kick_en_next;
			power_off_reg <= power_off_next;
			div_reg <= div_next;
			kick_sel_reg <= kick_sel_next;
			wake_flag_reg <= wake_flag_next;
			kick_flag_reg <= kick_flag_next;
			req_oe_reg <= req_oe_next;
			irq_oe_reg <= irq_oe_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// Open-drain pins only ever drive low; only the enables move, so a
	// released pin is left to its pull-up
	logic drive_low_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_low_reg <= 1'b0;
		end else if (ce) begin
			drive_low_reg <= 1'b0;
		end
	end

	assign rd_data = rd_data_reg;
	assign power_request_n_out = drive_low_reg;
	assign power_request_n_oe = req_oe_reg;
	assign clock_interrupt_n_out = drive_low_reg;
	assign clock_interrupt_n_oe = irq_oe_reg;

endmodule

// File: tb/wake_seq_monitor.sv
// Concurrent checks on the ports of the wake-up power sequencer.
// Assumes binding into wake_seq, ce low only while idle, one clock domain.
`timescale 1ns/100ps
module wake_seq_monitor
	import wake_seq_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_strobe,
	input wire logic alarm_match,
	input wire logic osc_running,
	input wire logic other_irq_pending,
	input wire logic power_good,
	input wire logic power_request_n_oe,
	input wire logic clock_interrupt_n_oe
);
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	int unsigned wait_reg;
	int unsigned wait_next;
	logic run;

	// Mirror of control writes and count of unpowered request cycles
	always_comb begin
		ctl_next = ctl_reg;
		if (ce && wr_strobe && addr == OFS_CONTROL)
			ctl_next = wr_data;
		wait_next = (power_request_n_oe && !power_good) ? wait_reg + 1 : 0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_reg <= 8'h04;
			wait_reg <= 0;
		end else begin
			ctl_reg <= ctl_next;
			wait_reg <= wait_next;
		end
	end
	assign run = osc_running && (ctl_reg[6:4] & DIV_RUN_MASK) == DIV_RUN_VAL;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Settled battery mode, and settled main supply
	sequence down_s;
		(!power_good && !power_request_n_oe)[*8];
	endsequence
	sequence powered_s;
		power_good[*8];
	endsequence

	a_request_holds: assert property (
		$rose(power_request_n_oe) |-> power_request_n_oe[*8])
		else $error("request dropped early");
	a_timeout_bound: assert property (wait_reg <= TIMEOUT_CYCLES)
		else $error("request outlived the timeout");
	a_irq_unpowered: assert property (
		(!power_good)[*8] |-> !clock_interrupt_n_oe)
		else $error("interrupt driven without supply");
	a_alarm_request: assert property (
		down_s ##0 (alarm_match && ctl_reg[CTL_WAKE_EN] && run)
		|=> power_request_n_oe) else $error("alarm gave no request");
	a_divider_block: assert property (
		down_s ##0 (alarm_match && !run) |=> !power_request_n_oe)
		else $error("request with divider in reset");
	a_flag_clear: assert property (
		ce && wr_strobe && addr == OFS_FLAGS && wr_data[1:0] == 2'h0
		&& !other_irq_pending && !alarm_match |=> !clock_interrupt_n_oe)
		else $error("interrupt kept after flag clear");
	a_power_off: assert property (
		powered_s ##0 (ce && wr_strobe && addr == OFS_CONTROL
		&& wr_data[CTL_POWER_OFF] && !alarm_match) |=> !power_request_n_oe)
		else $error("request kept after power off");
	a_other_irq: assert property (
		powered_s ##0 other_irq_pending |=> clock_interrupt_n_oe)
		else $error("other source gave no interrupt");
	a_rewake_on: assert property (
		powered_s ##0 (alarm_match && ctl_reg[CTL_WAKE_EN])
		|=> power_request_n_oe) else $error("no request while powered");
endmodule

bind wake_seq wake_seq_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
	.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
	.wr_strobe(wr_strobe), .alarm_match(alarm_match),
	.osc_running(osc_running), .other_irq_pending(other_irq_pending),
	.power_good(power_good), .power_request_n_oe(power_request_n_oe),
	.clock_interrupt_n_oe(clock_interrupt_n_oe));

// File: tb/supply_model.sv
// Main power supply and pull-ups on the two open-drain pins.
// Assumes the enables come straight from wake_seq.
`timescale 1ns/100ps
module supply_model #(
	parameter int DLY = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic ext_on,
	input wire logic req_oe,
	input wire logic irq_oe,
	output logic power_good,
	output logic req_pin,
	output logic irq_pin
);
	int cnt_reg;
	int cnt_next;

	// Count how long the request has been held
	always_comb begin
		cnt_next = req_oe ? cnt_reg + 1 : 0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_reg <= 0;
		else
			cnt_reg <= cnt_next;
	end
	// Supply up at once with ext_on, else rises after DLY cycles of request, never when slow
	assign power_good = ext_on || (!slow && cnt_reg >= DLY);
	// Released pins float up through the pull-ups
	assign req_pin = !req_oe;
	assign irq_pin = !irq_oe;
endmodule

// File: tb/wake_seq_tb_top.sv
// Self-checking bench for the wake-up power sequencer.
// Assumes the supply model and the bound checker are compiled with it.
`timescale 1ns/100ps
module wake_seq_tb_top;
	import wake_seq_pkg::*;
	localparam int TO = 20;
	logic clk = 0;
	logic rst = 1;
	logic ce = 1;
	logic [ADDR_W-1:0] addr = 0;
	logic [DATA_W-1:0] wr_data = 0;
	logic wr_strobe = 0;
	logic rd_strobe = 0;
	logic alarm_match = 0;
	logic osc_running = 1;
	logic other_irq_pending = 0;
	logic [3:0] kick = 4'hf;
	logic slow = 0;
	logic ext_on = 0;
	logic rd_seen = 0;
	logic [DATA_W-1:0] rd_data;
	logic power_good, req_oe, irq_oe, req_pin, irq_pin;
	logic [DATA_W-1:0] exp_q[$];
	logic [31:0] seed = 32'h0f6b5776;
	int mismatches = 0;
	int num_checks = 0;

	always #2 clk = ~clk;

	wake_seq #(.TIMEOUT_CYCLES(TO)) DUT (
		.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.power_good(power_good), .alarm_match(alarm_match),
		.osc_running(osc_running), .other_irq_pending(other_irq_pending),
		.keyboard_port_pin_sixteen(kick[0]),
		.serial_a_ring_indicate_n(kick[1]),
		.serial_b_ring_indicate_n(kick[2]), .infrared_receive_in(kick[3]),
		.power_request_n_in(req_pin), .power_request_n_out(),
		.power_request_n_oe(req_oe), .clock_interrupt_n_in(irq_pin),
		.clock_interrupt_n_out(), .clock_interrupt_n_oe(irq_oe));
	supply_model u_sup (.clk(clk), .rst(rst), .slow(slow), .ext_on(ext_on),
		.req_oe(req_oe), .irq_oe(irq_oe), .power_good(power_good),
		.req_pin(req_pin), .irq_pin(irq_pin));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	function automatic logic [7:0] sts(input logic pg, rq, iq,
		input logic [1:0] st);
		return {1'b0, !iq, !rq, st, iq, rq, pg};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1;
		@(posedge clk);
		wr_strobe <= 0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd_strobe <= 1;
		@(posedge clk);
		rd_strobe <= 0;
		@(posedge clk);
	endtask
	task automatic alarm();
		alarm_match <= 1;
		@(posedge clk);
		alarm_match <= 0;
		@(posedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Compare read data with the oldest queued expectation
	always @(posedge clk) begin
		if (rd_seen)
			chk(rd_data, exp_q.pop_front());
		rd_seen <= rd_strobe;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(OFS_CONTROL, 8'h04);
		rd(OFS_KICK_SEL, 8'h00);
		rd(4'h2, 8'h00);
		rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		seed = xs(seed);
		wr(OFS_KICK_SEL, {4'h0, seed[3:0]});
		rd(OFS_KICK_SEL, {4'h0, seed[3:0]});
		// Strobes are ignored while the clock enable is low
		ce <= 0;
		wr(OFS_KICK_SEL, {4'h0, ~seed[3:0]});
		ce <= 1;
		rd(OFS_KICK_SEL, {4'h0, seed[3:0]});
		$display("reset test done");
		// Alarm with the divider in reset sets only the flag
		wr(OFS_CONTROL, 8'h05);
		alarm();
		rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		rd(OFS_FLAGS, 8'h01);
		wr(OFS_FLAGS, 8'h00);
		// Oscillator stopped, then wake disabled: flag only, no request
		osc_running <= 0;
		wr(OFS_CONTROL, 8'h25);
		alarm();
		rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		osc_running <= 1;
		wr(OFS_CONTROL, 8'h24);
		alarm();
		rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		rd(OFS_FLAGS, 8'h01);
		wr(OFS_FLAGS, 8'h00);
		// Supply never comes, so the request times out
		slow <= 1;
		wr(OFS_CONTROL, 8'h25);
		alarm();
		#1 chk(req_oe, 1);
		repeat (TO + 6) @(posedge clk);
		rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		rd(OFS_FLAGS, 8'h01);
		wr(OFS_FLAGS, 8'h00);
		slow <= 0;
		$display("alarm tests done");
		// Each kick pin powers up; its neighbour is not selected
		for (int i = 0; i < NUM_KICK; i++) begin
			seed = xs(seed);
			wr(OFS_KICK_SEL, 8'(8'h01 << i));
			wr(OFS_CONTROL, 8'h26);
			kick[(i + 1) % 4] <= 0;
			repeat (10) @(posedge clk);
			kick[(i + 1) % 4] <= 1;
			rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
			kick[i] <= 0;
			repeat (4 + seed[2:0]) @(posedge clk);
			kick[i] <= 1;
			repeat (28) @(posedge clk);
			rd(OFS_STATUS, sts(1, 1, 1, ST_ON));
			rd(OFS_CONTROL, 8'h22);
			rd(OFS_FLAGS, 8'h02);
			wr(OFS_FLAGS, 8'h00);
			repeat (6) @(posedge clk);
			rd(OFS_STATUS, sts(1, 1, 0, ST_ON));
			wr(OFS_CONTROL, 8'h26);
			repeat (12) @(posedge clk);
			rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		end
		$display("kick tests done");
		// Power from elsewhere, another source, then an alarm
		ext_on <= 1;
		repeat (10) @(posedge clk);
		rd(OFS_STATUS, sts(1, 0, 0, ST_ON));
		other_irq_pending <= 1;
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, sts(1, 0, 1, ST_ON));
		other_irq_pending <= 0;
		wr(OFS_CONTROL, 8'h25);
		alarm();
		#1 chk(req_oe, 1);
		@(posedge clk);
		repeat (6) @(posedge clk);
		rd(OFS_STATUS, sts(1, 1, 1, ST_ON));
		rd(OFS_CONTROL, 8'h21);
		ext_on <= 0;
		wr(OFS_FLAGS, 8'h00);
		wr(OFS_CONTROL, 8'h25);
		repeat (12) @(posedge clk);
		rd(OFS_STATUS, sts(0, 0, 0, ST_DOWN));
		$display("powered tests done");
		repeat (2) @(posedge clk);
		print_verdict();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#(20000 * 4);
		mismatches++;
		print_verdict();
	end
endmodule
